// File: design/pdpc_control.sv
// APB register slave and first-synth power/calibration sequencer.
// Assumes an APB master on clk; analog PLL and output channels sit outside.
`timescale 1ns/100ps
`include "pdpc_map.svh"
module pdpc_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_pin,
    output logic [`PDPC_DIV_W-1:0] second_synth_m_ratio,
    output logic second_synth_m_bypass,
    output logic [3:0] first_synth_post_ratio,
    output logic first_synth_enable,
    output logic first_synth_cal_reset,
    output logic first_synth_cal_busy,
    output logic first_synth_sync
);
    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [4:0] pll1_control_zero;
    logic [4:0] second_synth_ref_divider;
    logic [8:0] cal_count;
    pdpc_pkg::pdpc_state_t state;
    pdpc_pkg::pdpc_state_t next_state;
    logic [2:0] sync_sh;
    logic sync_level;

    // Decode: zero-wait slave, so pready is constant high
    wire access = psel && penable;
    wire hit_ctrl0 = paddr == `PDPC_OFF_CTRL0;
    wire hit_mdiv = paddr == `PDPC_OFF_MDIV;
    wire hit_status = paddr == `PDPC_OFF_STATUS;
    wire mapped = hit_ctrl0 || hit_mdiv || hit_status;
    wire wr_ctrl0 = access && pwrite && hit_ctrl0;
    wire wr_mdiv = access && pwrite && hit_mdiv;
    wire first_synth_power_down = pll1_control_zero[`PDPC_PDN_BIT];
    wire first_synth_resync_enable = pll1_control_zero[`PDPC_SYNC_BIT];
    wire [2:0] first_synth_post_divider = pll1_control_zero[`PDPC_P_LSB +: 3];
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Register writes; bits 31:5 are dropped so they cannot steer anything
    always_ff @(posedge clk) begin
        if (reset) begin
            pll1_control_zero <= `PDPC_CTRL0_RESET;
            second_synth_ref_divider <= `PDPC_MDIV_RESET;
        end else begin
            if (wr_ctrl0) begin
                pll1_control_zero <= pwdata[4:0];
            end
            if (wr_mdiv) begin
                second_synth_ref_divider <= pwdata[4:0];
            end
        end
    end

    // Read data registered; upper bits always zero
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit_ctrl0 ? {27'h0, pll1_control_zero} :
                      hit_mdiv ? {27'h0, second_synth_ref_divider} :
                      hit_status ? {29'h0, first_synth_cal_busy, first_synth_enable, state == pdpc_pkg::PDPC_LOCKED} :
                      32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Divider ratio decode
    // ----------------------------------------
    function automatic logic [`PDPC_DIV_W-1:0] pdpc_plus_one(input logic [4:0] code);
        pdpc_plus_one = {1'b0, code} + 6'h01;
    endfunction : pdpc_plus_one

    // Post code plus one as a named wire, since a call result cannot be part-selected
    wire [`PDPC_DIV_W-1:0] post_plus_one = pdpc_plus_one({2'b00, first_synth_post_divider});

    // Registered ratios so the analog side never sees a decode glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            second_synth_m_ratio <= 6'h01;
            second_synth_m_bypass <= 1'b1;
            first_synth_post_ratio <= 4'h8;
        end else begin
            second_synth_m_bypass <= second_synth_ref_divider == 5'h00;
            second_synth_m_ratio <= (second_synth_ref_divider == 5'h00) ? 6'h01
                : pdpc_plus_one(second_synth_ref_divider);
            first_synth_post_ratio <= (first_synth_post_divider < 3'h2) ? 4'h2
                : post_plus_one[3:0];
        end
    end

    // ----------------------------------------
    // Power and calibration sequencer
    // ----------------------------------------
    // Reset lands in OFF; the power-down bit then decides whether calibration starts
    always_comb begin
        next_state = state;
        case (state)
            pdpc_pkg::PDPC_OFF: if (!first_synth_power_down) next_state = pdpc_pkg::PDPC_CAL;
            pdpc_pkg::PDPC_CAL: begin
                if (first_synth_power_down) next_state = pdpc_pkg::PDPC_OFF;
                else if (cal_count == 9'h001) next_state = pdpc_pkg::PDPC_LOCKED;
            end
            pdpc_pkg::PDPC_LOCKED: if (first_synth_power_down) next_state = pdpc_pkg::PDPC_OFF;
            default: next_state = pdpc_pkg::PDPC_OFF;
        endcase
    end

    // Calibration counter restarts at full length on every entry
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= pdpc_pkg::PDPC_OFF;
            cal_count <= 9'h000;
        end else begin
            state <= next_state;
            if (next_state == pdpc_pkg::PDPC_CAL && state != pdpc_pkg::PDPC_CAL) begin
                cal_count <= 9'(`PDPC_CAL_CYCLES);
            end else if (cal_count != 9'h000) begin
                cal_count <= cal_count - 9'h001;
            end
        end
    end

    assign first_synth_enable = state != pdpc_pkg::PDPC_OFF;
    assign first_synth_cal_reset = state == pdpc_pkg::PDPC_OFF;
    assign first_synth_cal_busy = state == pdpc_pkg::PDPC_CAL;

    // ----------------------------------------
    // Sync event gating
    // ----------------------------------------
    // Pin is asynchronous: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_sh <= 3'h0;
            sync_level <= 1'b0;
            first_synth_sync <= 1'b0;
        end else begin
            sync_sh <= {sync_sh[1:0], sync_pin};
            if (sync_sh[1] == sync_sh[2]) sync_level <= sync_sh[2];
            first_synth_sync <= (sync_sh[1] == sync_sh[2]) && sync_sh[2] && !sync_level
                && first_synth_resync_enable;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_mdiv_bypass_zero: assert property (@(posedge clk) disable iff (reset)
        second_synth_ref_divider == 5'h00 |=> second_synth_m_bypass && second_synth_m_ratio == 6'h01)
        else $error("zero M code did not bypass");
    a_mdiv_ratio_plus: assert property (@(posedge clk) disable iff (reset)
        second_synth_ref_divider != 5'h00 |=> second_synth_m_ratio == {1'b0, $past(second_synth_ref_divider)} + 6'h01)
        else $error("M ratio is not code plus one");
    a_post_div_low: assert property (@(posedge clk) disable iff (reset)
        first_synth_post_divider < 3'h2 |=> first_synth_post_ratio == 4'h2)
        else $error("low post code not divide by two");
    a_post_div_high: assert property (@(posedge clk) disable iff (reset)
        first_synth_post_divider >= 3'h2 |=> first_synth_post_ratio == {1'b0, $past(first_synth_post_divider)} + 4'h1)
        else $error("post ratio is not code plus one");
    a_sync_gated_off: assert property (@(posedge clk) disable iff (reset)
        !first_synth_resync_enable |=> !first_synth_sync)
        else $error("sync passed while disabled");
    a_sync_passes_on: assert property (@(posedge clk) disable iff (reset)
        first_synth_resync_enable && sync_sh[1] && sync_sh[2] && !sync_level |=> first_synth_sync)
        else $error("enabled sync event lost");
    a_pdn_holds_off: assert property (@(posedge clk) disable iff (reset)
        first_synth_power_down ##1 first_synth_power_down |-> !first_synth_enable && first_synth_cal_reset)
        else $error("synth active while powered down");
    a_pdn_clear_recal: assert property (@(posedge clk) disable iff (reset)
        $fell(first_synth_power_down) |=> first_synth_cal_busy && cal_count == 9'(`PDPC_CAL_CYCLES))
        else $error("calibration not restarted");
    a_reset_autostart: assert property (@(posedge clk)
        $fell(reset) && !first_synth_power_down |=> first_synth_cal_busy)
        else $error("no calibration after reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
        prdata[31:5] == 27'h0)
        else $error("reserved bits read nonzero");
    c_cal_done: cover property (@(posedge clk) disable iff (reset) $rose(state == pdpc_pkg::PDPC_LOCKED));
    c_power_cycle: cover property (@(posedge clk) disable iff (reset) $rose(first_synth_power_down));
    c_sync_out: cover property (@(posedge clk) disable iff (reset) first_synth_sync);
    // Sequencer checks: reset, power-down and calibration length
    a_reset_lands_off: assert property (@(posedge clk)
        reset |=> first_synth_cal_reset && !first_synth_enable && !first_synth_sync)
        else $error("synth active during reset");
    a_reset_ratios: assert property (@(posedge clk)
        reset |=> second_synth_m_bypass && first_synth_post_ratio == 4'h8)
        else $error("ratio outputs wrong after reset");
    a_enable_tracks_pdn: assert property (@(posedge clk) disable iff (reset)
        !first_synth_power_down ##1 !first_synth_power_down |-> first_synth_enable)
        else $error("synth not enabled with power-down clear");
    a_cal_hold_reset: assert property (@(posedge clk) disable iff (reset)
        first_synth_power_down |=> first_synth_cal_reset && !first_synth_cal_busy)
        else $error("calibration not held in reset");
    a_cal_full_length: assert property (@(posedge clk) disable iff (reset)
        $rose(first_synth_cal_busy) |-> cal_count == 9'(`PDPC_CAL_CYCLES))
        else $error("calibration did not start from the beginning");
    a_cal_ends_locked: assert property (@(posedge clk) disable iff (reset)
        first_synth_cal_busy && cal_count == 9'h001 && !first_synth_power_down |=> state == pdpc_pkg::PDPC_LOCKED)
        else $error("calibration did not finish");
    // Register checks: only bits 4:0 of a write are stored; then the one-cycle sync pulse check
    a_ctrl_write_low: assert property (@(posedge clk) disable iff (reset)
        wr_ctrl0 |=> pll1_control_zero == $past(pwdata[4:0]))
        else $error("control write not stored from low bits");
    a_mdiv_write_low: assert property (@(posedge clk) disable iff (reset)
        wr_mdiv |=> second_synth_ref_divider == $past(pwdata[4:0]))
        else $error("M divider write not stored from low bits");
    a_sync_one_pulse: assert property (@(posedge clk) disable iff (reset)
        first_synth_sync |=> !first_synth_sync)
        else $error("one sync event gave a long pulse");
    // Covers: a blocked sync event and the largest M ratio
    c_sync_blocked: cover property (@(posedge clk) disable iff (reset)
        !first_synth_resync_enable && sync_sh[1] && sync_sh[2] && !sync_level);
    c_mdiv_max: cover property (@(posedge clk) disable iff (reset) second_synth_m_ratio == 6'h20);
endmodule : pdpc_control

// File: design/pdpc_map.svh
// Offsets, field positions, reset values and timing counts for the PLL divider/power block.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef PDPC_MAP_SVH
`define PDPC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDPC_OFF_CTRL0 12'h038
`define PDPC_OFF_MDIV 12'h03c
`define PDPC_OFF_STATUS 12'h040
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PDPC_PDN_BIT 0
`define PDPC_SYNC_BIT 1
`define PDPC_P_LSB 2
`define PDPC_CTRL0_RESET 5'h1e
`define PDPC_MDIV_RESET 5'h00
`define PDPC_DIV_W 6
`define PDPC_CAL_TIME_NS 400
`define PDPC_CAL_CYCLES ((`PDPC_CAL_TIME_NS + 3) / 4)
`endif

// File: design/pdpc_pkg.sv
// Types shared by the PLL divider/power block.
// Assumes pdpc_map.svh for numeric constants.
package pdpc_pkg;
    typedef enum logic [1:0] {
        PDPC_OFF,
        PDPC_CAL,
        PDPC_LOCKED
    } pdpc_state_t;
endpackage : pdpc_pkg

// File: bench/tb_top.sv
// Self-checking bench for the PLL divider and power-down control block.
// Assumes pdpc_control and pdpc_map.svh; this bench is the only APB master.
`timescale 1ns/100ps
`include "pdpc_map.svh"
module tb_top;
    logic clk, reset, psel, penable, pwrite, sync_pin, pready, pslverr, m_bypass, err;
    logic en, cal_rst, busy, sync_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, n, ex;
    logic [5:0] m_ratio;
    logic [3:0] post_ratio;
    logic [4:0] mc [4] = '{5'h00, 5'h01, 5'h0a, 5'h1f};
    int err_count = 0, tests_run = 0, cycles = 0;
    pdpc_control u_pdpc_control (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_pin(sync_pin), .second_synth_m_ratio(m_ratio), .second_synth_m_bypass(m_bypass),
        .first_synth_post_ratio(post_ratio), .first_synth_enable(en), .first_synth_cal_reset(cal_rst),
        .first_synth_cal_busy(busy), .first_synth_sync(sync_out));
    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run is well under a thousand cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            results();
        end
    end
    // ----------------------------------------
    // Bus, compare and report tasks
    // ----------------------------------------
    // Request held until pready is seen high; data and error taken at that edge only
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Sample away from the edge so the edge's updates have landed
    task settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // One-cycle sync pulses are counted once each at the falling edge
    task pulse_sync(output logic [31:0] c);
        c = 0;
        @(posedge clk);
        sync_pin <= 1'b1;
        repeat (12) begin
            @(negedge clk);
            c = c + {31'h0, sync_out};
        end
        @(posedge clk);
        sync_pin <= 1'b0;
        settle(4);
    endtask : pulse_sync
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {reset, psel, penable, pwrite, sync_pin, paddr, pwdata} = {1'b1, 4'h0, 12'h000, 32'h0};
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        chk({30'h0, en, busy}, 32'h3);
        chk({27'h0, m_bypass, post_ratio}, 32'h18);
        apb(1'b0, `PDPC_OFF_CTRL0, 32'h0, rd, err);
        chk(rd, 32'h1e);
        $display("test reset done");
        // M divider codes with reserved bits set on every write
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `PDPC_OFF_MDIV, 32'hffffffe0 | mc[i], rd, err);
            apb(1'b0, `PDPC_OFF_MDIV, 32'h0, rd, err);
            chk(rd, {27'h0, mc[i]});
            settle(1);
            ex = (mc[i] == 5'h00) ? 32'h41 : {26'h0, 1'b0, 5'(mc[i] + 5'h01)} + ((mc[i] == 5'h1f) ? 32'h20 : 32'h0);
            chk({25'h0, m_bypass, m_ratio}, ex);
        end
        $display("test m divider done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `PDPC_OFF_CTRL0, 32'hffffffe2 | (c << 2), rd, err);
            settle(2);
            chk({28'h0, post_ratio}, (c < 2) ? 32'h2 : c + 1);
            apb(1'b0, `PDPC_OFF_CTRL0, 32'h0, rd, err);
            chk(rd, 32'h2 | (c << 2));
        end
        $display("test post divider done");
        apb(1'b1, `PDPC_OFF_CTRL0, 32'h1f, rd, err);
        settle(20);
        chk({29'h0, en, cal_rst, busy}, 32'h2);
        apb(1'b0, `PDPC_OFF_STATUS, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b1, `PDPC_OFF_CTRL0, 32'h1e, rd, err);
        settle(90);
        chk({29'h0, en, cal_rst, busy}, 32'h5);
        apb(1'b0, `PDPC_OFF_STATUS, 32'h0, rd, err);
        chk(rd, 32'h6);
        settle(15);
        chk({29'h0, en, cal_rst, busy}, 32'h4);
        apb(1'b0, `PDPC_OFF_STATUS, 32'h0, rd, err);
        chk(rd, 32'h3);
        $display("test power down done");
        pulse_sync(n);
        chk(n, 32'h1);
        apb(1'b1, `PDPC_OFF_CTRL0, 32'h1c, rd, err);
        pulse_sync(n);
        chk(n, 32'h0);
        $display("test resync done");
        // Reset in mid-run with power-down set: registers reload, calibration restarts
        apb(1'b1, `PDPC_OFF_CTRL0, 32'h1d, rd, err);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        settle(1);
        chk({29'h0, en, cal_rst, busy}, 32'h5);
        apb(1'b0, `PDPC_OFF_CTRL0, 32'h0, rd, err);
        chk(rd, 32'h1e);
        $display("test mid-run reset done");
        apb(1'b0, 12'h100, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        $display("test unmapped done");
        results();
    end
endmodule : tb_top
